// *** asram_host.sv ***
// host controller driving an asynchronous 16-bit sram with byte lanes
// assumes request pins synchronous to CLK and the sram wired directly to the pin outputs
// limitation: slow-grade timing serves both grades, which costs fast parts a little speed
`timescale 1ns/1ps
module asram_host (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic REQ_VALID,
  input wire asram_pkg::asram_req_type REQ,
  output logic REQ_READY,
  output logic RSP_VALID,
  output logic [asram_pkg::ASRAM_DW-1:0] RSP_RDATA,
  output asram_pkg::asram_pins_type PINS,
  input wire logic [asram_pkg::ASRAM_DW-1:0] DQ_IN,
  output logic [asram_pkg::ASRAM_DW-1:0] DQ_OUT,
  output logic [1:0] DQ_OE
);
  import asram_pkg::*;

  // one access in flight at a time; req_q keeps its fields for the whole access
  asram_state_type state_q;
  logic [3:0] cnt_q;
  asram_req_type req_q;

  function automatic logic [ASRAM_DW-1:0] lane_mask(input logic [1:0] lanes);
    return {{8{lanes[1]}}, {8{lanes[0]}}};
  endfunction

  // a request with no lane set is dropped: the memory would neither store nor return data
  function automatic logic req_takeable(input logic valid, input asram_req_type req);
    return valid && req.lanes != 2'b00;
  endfunction

  // every timed phase counts down to one, so a loaded count is its length in cycles
  function automatic logic phase_last(input logic [3:0] cnt);
    return cnt == 4'h1;
  endfunction

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (req_takeable(REQ_VALID, REQ)) begin
            state_q <= REQ.write ? ST_WFLT : ST_RACC;
          end
        end
        ST_WFLT: begin
          // memory may still drive; wait out its float time before driving data
          if (phase_last(cnt_q)) begin
            state_q <= ST_WLOW;
          end
        end
        ST_WLOW: begin
          // strobe low for the whole phase; its rising edge ends the write
          if (phase_last(cnt_q)) begin
            state_q <= ST_WEND;
          end
        end
        ST_WEND: begin
          // strobe already high; pins stay put this cycle for address and data hold
          state_q <= ST_IDLE;
        end
        ST_RACC: begin
          if (phase_last(cnt_q)) begin
            state_q <= ST_RTURN;
          end
        end
        ST_RTURN: begin
          // hold off the next access until the memory has floated the bus
          if (phase_last(cnt_q)) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // phase counter
  // ----------------------------------------------------------------
  // loaded on entry to each timed phase, then counted down to one
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cnt_q <= CNT_RESET;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (req_takeable(REQ_VALID, REQ)) begin
            cnt_q <= REQ.write ? FLOAT_CYC : RD_ACCESS_CYC;
          end
        end
        ST_WFLT: begin
          cnt_q <= phase_last(cnt_q) ? WR_LOW_CYC : cnt_q - 4'h1;
        end
        ST_WLOW: begin
          if (!phase_last(cnt_q)) begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        ST_WEND: begin
          cnt_q <= CNT_RESET;
        end
        ST_RACC: begin
          cnt_q <= phase_last(cnt_q) ? TURN_CYC : cnt_q - 4'h1;
        end
        ST_RTURN: begin
          if (!phase_last(cnt_q)) begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        default: begin
          cnt_q <= CNT_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      req_q <= '0;
    end else if (state_q == ST_IDLE && REQ_VALID) begin
      req_q <= REQ;
    end
  end

  // ----------------------------------------------------------------
  // memory pins
  // ----------------------------------------------------------------
  // address, selects and lanes go active with the strobe still high and stay put until
  // two cycles after the strobe rises, so the strobe's rising edge ends every write
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PINS <= PINS_IDLE;
    end else begin
      PINS <= PINS_IDLE;
      case (state_q)
        ST_IDLE: begin
          if (req_takeable(REQ_VALID, REQ)) begin
            PINS.addr <= REQ.addr;
            PINS.select_low_active <= 1'b0;
            PINS.select_high_active <= 1'b1;
            PINS.upper_lane_enable_n <= ~REQ.lanes[1];
            PINS.lower_lane_enable_n <= ~REQ.lanes[0];
            PINS.oe_n <= REQ.write;
          end
        end
        ST_WFLT, ST_WLOW, ST_WEND, ST_RACC: begin
          PINS.addr <= req_q.addr;
          PINS.select_low_active <= 1'b0;
          PINS.select_high_active <= 1'b1;
          PINS.upper_lane_enable_n <= ~req_q.lanes[1];
          PINS.lower_lane_enable_n <= ~req_q.lanes[0];
          PINS.oe_n <= req_q.write;
          // strobe low only while all qualifiers are already set
          PINS.we_n <= ~(state_q == ST_WFLT && phase_last(cnt_q) ||
                         state_q == ST_WLOW && !phase_last(cnt_q));
        end
        ST_RTURN: begin
          // deselected; address left in place so the memory sees no extra transition
          PINS.addr <= req_q.addr;
        end
        default: begin
          PINS.addr <= ADDR_RESET;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // data bus
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      DQ_OUT <= DATA_RESET;
      DQ_OE <= 2'b00;
    end else begin
      // drive from strobe fall through two cycles past its rise: setup and zero hold met
      if ((state_q == ST_WFLT && phase_last(cnt_q)) || state_q == ST_WLOW) begin
        DQ_OUT <= req_q.wdata;
        DQ_OE <= req_q.lanes;
      end else if (state_q == ST_WEND) begin
        // keeps data out for the second cycle after the strobe rises: two full cycles of hold
        DQ_OUT <= req_q.wdata;
        DQ_OE <= req_q.lanes;
      end else begin
        DQ_OE <= 2'b00;
      end
    end
  end

  // ----------------------------------------------------------------
  // request handshake and read answer
  // ----------------------------------------------------------------
  // ready mirrors the idle state, so it never promises an edge the sequencer will not take
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      REQ_READY <= 1'b1;
    end else begin
      REQ_READY <= (state_q == ST_IDLE && !req_takeable(REQ_VALID, REQ)) ||
                   state_q == ST_WEND || (state_q == ST_RTURN && phase_last(cnt_q));
    end
  end

  // disabled lanes read as zero rather than whatever the floating bus shows
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RSP_VALID <= 1'b0;
      RSP_RDATA <= DATA_RESET;
    end else begin
      RSP_VALID <= 1'b0;
      if (state_q == ST_RACC && phase_last(cnt_q)) begin
        RSP_VALID <= 1'b1;
        RSP_RDATA <= DQ_IN & lane_mask(req_q.lanes);
      end
    end
  end

endmodule // asram_host

// *** asram_monitor.sv ***
// pin checker for the sram host controller
// bound to every asram_host; sees its ports only
`timescale 1ns/1ps
module asram_monitor (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire asram_pkg::asram_pins_type PINS,
  input wire logic [1:0] DQ_OE,
  input wire logic [asram_pkg::ASRAM_DW-1:0] DQ_OUT
);
  import asram_pkg::*;
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  wire sel = !PINS.select_low_active && PINS.select_high_active;
  wire lane = !(PINS.upper_lane_enable_n && PINS.lower_lane_enable_n);
  // strobe-low length in cycles, read back at the rising edge of the strobe
  logic [3:0] low_cyc_q;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      low_cyc_q <= 4'h0;
    end else if (PINS.we_n) begin
      low_cyc_q <= 4'h0;
    end else if (low_cyc_q != 4'hF) begin
      low_cyc_q <= low_cyc_q + 4'h1;
    end
  end
  wire pulse_ok = int'(low_cyc_q) * CLK_PERIOD_NS >= WRITE_PULSE_WIDTH_NS &&
    int'(low_cyc_q) * CLK_PERIOD_NS > WRITE_TO_FLOAT_TIME_NS + WRITE_DATA_SETUP_NS;
  a_oe_off_write: assert property (!PINS.we_n |-> PINS.oe_n)
    else $error("output enable low in write");
  a_no_fight: assert property (!PINS.oe_n |-> DQ_OE == 2'b00)
    else $error("host drives during read");
  a_write_start: assert property ($fell(PINS.we_n) |-> sel && lane && $past(PINS.oe_n))
    else $error("strobe fell unqualified");
  a_pulse_width: assert property ($rose(PINS.we_n) |-> pulse_ok)
    else $error("strobe pulse too short");
  a_addr_setup: assert property ($rose(PINS.we_n) |-> PINS.addr == $past(PINS.addr, 2))
    else $error("address setup short");
  a_addr_steady: assert property (!PINS.we_n |=> $stable(PINS.addr))
    else $error("address moved in write");
  a_sel_setup: assert property ($rose(PINS.we_n) |-> sel && $past(sel && lane, 2))
    else $error("select or lane setup short");
  a_data_setup: assert property ($rose(PINS.we_n) |-> DQ_OE != 2'b00 && $stable(DQ_OUT))
    else $error("data not held to write end");
endmodule // asram_monitor
bind asram_host asram_monitor i_asram_monitor (.CLK(CLK), .ARST_N(ARST_N), .PINS(PINS),
  .DQ_OE(DQ_OE), .DQ_OUT(DQ_OUT));

// *** asram_pkg.sv ***
// package for the asynchronous sram host controller: pin bundles, timing figures, states
// assumes a single 20 MHz clock; all counts derived from nanosecond figures at that rate
package asram_pkg;

  localparam int ASRAM_AW = 20;
  localparam int ASRAM_DW = 16;
  localparam int CLK_PERIOD_NS = 50;

  // slow grade figures cover both grades
  localparam int ADDR_TO_WRITE_END_NS = 40;
  localparam int WRITE_PULSE_WIDTH_NS = 40;
  localparam int WRITE_DATA_SETUP_NS = 25;
  localparam int WRITE_TO_FLOAT_TIME_NS = 20;
  localparam int OE_TO_FLOAT_TIME_NS = 20;
  localparam int SELECT_ACCESS_TIME_NS = 55;
  localparam int LANE_ACCESS_TIME_NS = 55;
  localparam int LANE_FLOAT_TIME_NS = 20;

  function automatic int ns_to_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // strobe low long enough for address/select/lane setup and float plus data setup
  localparam int WR_LOW_NS_A = ADDR_TO_WRITE_END_NS;
  localparam int WR_LOW_NS_B = WRITE_TO_FLOAT_TIME_NS + WRITE_DATA_SETUP_NS + 1;
  localparam int WR_LOW_NS = (WR_LOW_NS_A > WR_LOW_NS_B) ? WR_LOW_NS_A : WR_LOW_NS_B;
  localparam logic [3:0] WR_LOW_CYC = 4'(ns_to_cycles(WR_LOW_NS));
  localparam logic [3:0] FLOAT_CYC = 4'(ns_to_cycles(WRITE_TO_FLOAT_TIME_NS));
  localparam logic [3:0] RD_ACCESS_CYC = 4'(ns_to_cycles(SELECT_ACCESS_TIME_NS));
  localparam logic [3:0] TURN_CYC = 4'(ns_to_cycles(OE_TO_FLOAT_TIME_NS));

  localparam logic [ASRAM_AW-1:0] ADDR_RESET = 20'h0_0000;
  localparam logic [ASRAM_DW-1:0] DATA_RESET = 16'h0000;
  localparam logic [3:0] CNT_RESET = 4'h0;

  // pins as seen at the memory, low-active strobes carry _n
  typedef struct packed {
    logic [ASRAM_AW-1:0] addr;
    logic select_low_active;
    logic select_high_active;
    logic upper_lane_enable_n;
    logic lower_lane_enable_n;
    logic oe_n;
    logic we_n;
  } asram_pins_type;

  typedef struct packed {
    logic write;
    logic [1:0] lanes;
    logic [ASRAM_AW-1:0] addr;
    logic [ASRAM_DW-1:0] wdata;
  } asram_req_type;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_WFLT  = 3'b001,
    ST_WLOW  = 3'b010,
    ST_WEND  = 3'b011,
    ST_RACC  = 3'b100,
    ST_RTURN = 3'b101
  } asram_state_type;

  localparam asram_pins_type PINS_IDLE = '{addr: ADDR_RESET, select_low_active: 1'b1,
    select_high_active: 1'b0, upper_lane_enable_n: 1'b1, lower_lane_enable_n: 1'b1,
    oe_n: 1'b1, we_n: 1'b1};

endpackage

// *** asram_sram_model.sv ***
// behavioural byte-lane sram on the host pins
// assumes the host is the only other bus driver
`timescale 1ns/1ps
module asram_sram_model (
  input wire asram_pkg::asram_pins_type p,
  input wire logic [15:0] dq_out,
  input wire logic [1:0] dq_oe,
  output logic [15:0] dq_in,
  output logic clash
);
  import asram_pkg::*;
  logic [15:0] mem [0:(1 << ASRAM_AW) - 1];
  logic [15:0] w;
  logic [15:0] rd;
  logic [1:0] drv;
  wire [15:0] rd_late;
  wire [1:0] drv_on;
  wire [1:0] live;
  wire sel = !p.select_low_active && p.select_high_active;
  wire [1:0] ln = ~{p.upper_lane_enable_n, p.lower_lane_enable_n};
  initial clash = 1'b0;
  // unwritten words read as zero
  initial begin
    for (int i = 0; i < (1 << ASRAM_AW); i++) begin
      mem[i] = 16'h0000;
    end
  end
  always @(p or dq_out or dq_oe) begin
    drv = (sel && p.we_n && !p.oe_n) ? ln : 2'b00;
    if (sel && ln != 2'b00 && !p.we_n) begin
      w = mem[p.addr];
      if (ln[0]) w[7:0] = dq_oe[0] ? dq_out[7:0] : 8'hxx;
      if (ln[1]) w[15:8] = dq_oe[1] ? dq_out[15:8] : 8'hxx;
      mem[p.addr] = w;
    end
    rd = mem[p.addr];
  end
  // data settles only after the slow-grade access time
  assign #(SELECT_ACCESS_TIME_NS) rd_late = rd;
  assign #10 drv_on = drv;
  assign live = drv & drv_on;
  // a released lane shows the inverse so a late sample cannot match
  always @(live or rd_late) begin
    dq_in[7:0] = live[0] ? rd_late[7:0] : ~rd_late[7:0];
    dq_in[15:8] = live[1] ? rd_late[15:8] : ~rd_late[15:8];
  end
  always @(live or dq_oe) if (|(live & dq_oe)) clash = 1'b1;
endmodule // asram_sram_model

// *** tb_top.sv ***
// testbench: host controller against the sram model
// one 20 MHz clock, nothing else on the pins
`timescale 1ns/1ps
module tb_top;
  import asram_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic req_valid = 1'b0;
  asram_req_type req = '0;
  logic req_ready, rsp_valid, clash;
  logic [15:0] rsp_rdata, dq_in, dq_out;
  logic [1:0] dq_oe;
  asram_pins_type pins;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  asram_host i_asram_host (.CLK(clk), .ARST_N(arst_n), .REQ_VALID(req_valid), .REQ(req),
    .REQ_READY(req_ready), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata), .PINS(pins),
    .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE(dq_oe));
  asram_sram_model i_asram_sram_model (.p(pins), .dq_out(dq_out), .dq_oe(dq_oe),
    .dq_in(dq_in), .clash(clash));
  initial forever #25 clk = ~clk;
  task automatic tally_and_finish();
    if (failures == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic issue(input logic wr, input logic [1:0] l, input logic [19:0] a,
      input logic [15:0] d);
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{write: wr, lanes: l, addr: a, wdata: d};
    do @(negedge clk); while (req_ready !== 1'b1);
    @(posedge clk);
    req_valid <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] l, input logic [19:0] a, input logic [15:0] e);
    issue(1'b0, l, a, 16'h0000);
    do @(negedge clk); while (rsp_valid !== 1'b1);
    check("rdata", rsp_rdata, e);
  endtask
  task automatic sc_lanes();
    issue(1'b1, 2'b11, 20'h1_2345, 16'hA5C3);
    issue(1'b1, 2'b10, 20'h1_2345, 16'h7E11);
    issue(1'b1, 2'b01, 20'h1_2345, 16'h5599);
    rd(2'b11, 20'h1_2345, 16'h7E99);
    rd(2'b10, 20'h1_2345, 16'h7E00);
    rd(2'b01, 20'h1_2345, 16'h0099);
  endtask
  task automatic sc_edges();
    issue(1'b1, 2'b11, 20'hF_FFFF, 16'hFFFF);
    issue(1'b1, 2'b11, 20'h0_0000, 16'h1234);
    rd(2'b11, 20'hF_FFFF, 16'hFFFF);
    rd(2'b11, 20'h0_0000, 16'h1234);
  endtask
  task automatic sc_no_lanes();
    issue(1'b1, 2'b00, 20'h1_2345, 16'hDEAD);
    repeat (3) begin
      @(negedge clk);
      check("pins", pins, PINS_IDLE);
    end
    rd(2'b11, 20'h1_2345, 16'h7E99);
  endtask
  task automatic sc_reset_mid();
    issue(1'b1, 2'b11, 20'h0_0042, 16'hBEEF);
    @(posedge clk);
    arst_n <= 1'b0;
    @(negedge clk);
    check("pins", pins, PINS_IDLE);
    check("dq_oe", dq_oe, 2'b00);
    @(posedge clk);
    arst_n <= 1'b1;
    issue(1'b1, 2'b01, 20'h0_0042, 16'h0077);
    rd(2'b01, 20'h0_0042, 16'h0077);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    sc_lanes();
    sc_edges();
    sc_no_lanes();
    sc_reset_mid();
    check("clash", clash, 1'b0);
    tally_and_finish();
  end
endmodule // tb_top
